// [rtl/scr_pkg.sv]
// constants, field layouts and state codes for the sdram configuration and refresh block
// assumes one 25 MHz clock and a byte-addressed register port driven by a simple master
// Operation
// - cas latency code 2h..5h selects read latency 2..5; other codes reserved
// - bank field 0..3h selects 1, 2, 4 or 8 internal banks
// - page field 0..3h selects 256..2048-word pages with 8..11 column bits
// - self-refresh bit at 1 enters self-refresh, at 0 leaves it
// - memory clock may stop only while clock-stop permission bit is 1
// - clock stopping only happens while in self-refresh, never in normal operation
// - auto-refresh interval comes from the 16-bit refresh-interval field
// - refresh-interval write below 0100h loads twice the refresh-recovery field
// - first timing register accepts writes only while timing unlock is 1
// - changing drive, cas latency, bank count or page size starts initialization
// - refresh-recovery field sits in bits 31-25 of first timing register
// - timing unlock bit 15 gates writes to both timing registers
package scr_pkg;

    localparam logic [7:0]  SCR_OFS_STATUS     = 8'h00;
    localparam logic [7:0]  SCR_OFS_BANK       = 8'h08;
    localparam logic [7:0]  SCR_OFS_REFRESH    = 8'h0c;
    localparam logic [7:0]  SCR_OFS_TIM1       = 8'h10;
    localparam logic [7:0]  SCR_OFS_TIM2       = 8'h14;

    localparam int          SCR_BC_BOOT_UNLOCK = 23;
    localparam int          SCR_BC_DRIVE       = 18;
    localparam int          SCR_BC_TIM_UNLOCK  = 15;
    localparam int          SCR_BC_CL_LSB      = 9;
    localparam int          SCR_BC_BANK_LSB    = 4;
    localparam int          SCR_BC_PAGE_LSB    = 0;
    localparam logic [31:0] SCR_BC_WMASK       = 32'h0080ce77;
    localparam logic [31:0] SCR_BC_FIXED       = 32'h00130000;
    localparam logic [31:0] SCR_BC_RESET       = 32'h00170a20;

    localparam int          SCR_RC_SELF_REF    = 31;
    localparam int          SCR_RC_CLK_STOP    = 30;
    localparam logic [31:0] SCR_RC_WMASK       = 32'hc080ffff;
    localparam logic [31:0] SCR_RC_RESET       = 32'h00000884;
    localparam logic [15:0] SCR_RR_MIN         = 16'h0100;

    localparam int          SCR_T1_RFC_LSB     = 25;
    localparam logic [31:0] SCR_T1_WMASK       = 32'hfffffffb;
    localparam logic [31:0] SCR_T1_RESET       = 32'h00000000;
    localparam logic [31:0] SCR_T2_WMASK       = 32'h01ffffff;
    localparam logic [31:0] SCR_T2_RESET       = 32'h001df145;

    localparam int          SCR_ST_SR_ACTIVE   = 0;
    localparam int          SCR_ST_CLK_STOP    = 1;
    localparam int          SCR_ST_SUPPORTED   = 2;
    localparam int          SCR_ST_COUNT_LSB   = 16;

    typedef enum logic [1:0] {
        SCR_NORMAL   = 2'b00,
        SCR_IN_SR    = 2'b01,
        SCR_CLK_STOP = 2'b10
    } scr_sr_state_t;

endpackage : scr_pkg

// [rtl/scr_refresh_timer.sv]
// refresh interval counter: one request pulse per programmed interval
// assumes interval and restart come from logic on the same clock
module scr_refresh_timer
    import scr_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clock,           // system clock
    input  wire logic         rst,             // async reset, active high
    input  wire logic         enable,          // counting allowed
    input  wire logic         restart,         // interval rewritten
    input  wire logic [W-1:0] interval,        // cycles per refresh
    output logic              refresh_request, // one-cycle request pulse
    output logic [W-1:0]      count            // current count
);

    logic [W:0] cnt_plus;
    logic       hit;

    assign cnt_plus = {1'b0, count} + {{W{1'b0}}, 1'b1};
    // an interval of 0 or 1 requests every cycle rather than wrapping
    assign hit      = cnt_plus >= {1'b0, interval};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (restart || !enable) begin
            count <= '0;
        end else if (hit) begin
            count <= '0;
        end else begin
            count <= cnt_plus[W-1:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refresh_request <= 1'b0;
        end else begin
            refresh_request <= enable && !restart && hit;
        end
    end

    a_refresh_off: assert property (@(posedge clock) disable iff (rst)
        !enable |=> !refresh_request)
        else $error("refresh request while counting disabled");

    a_refresh_restart: assert property (@(posedge clock) disable iff (rst)
        refresh_request |-> count == '0)
        else $error("count not restarted after request");

endmodule : scr_refresh_timer

// [rtl/scr_self_refresh_fsm.sv]
// self-refresh and memory clock stop sequencing
// assumes request bits come straight from the register file
module scr_self_refresh_fsm
    import scr_pkg::*;
(
    input  wire logic clock,         // system clock
    input  wire logic rst,           // async reset, active high
    input  wire logic sr_req,        // self-refresh request bit
    input  wire logic stop_allow,    // clock-stop permission bit
    output logic      sr_active,     // memory held in self-refresh
    output logic      clock_stop_ok  // memory clock may be stopped
);

    scr_sr_state_t state_r, state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SCR_NORMAL: begin
                if (sr_req) state_nxt = SCR_IN_SR;
            end
            SCR_IN_SR: begin
                if (!sr_req) state_nxt = SCR_NORMAL;
                else if (stop_allow) state_nxt = SCR_CLK_STOP;
            end
            SCR_CLK_STOP: begin
                // leaving self-refresh restarts the clock in the same step
                if (!sr_req) state_nxt = SCR_NORMAL;
                else if (!stop_allow) state_nxt = SCR_IN_SR;
            end
            default: state_nxt = SCR_NORMAL;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r       <= SCR_NORMAL;
            sr_active     <= 1'b0;
            clock_stop_ok <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            sr_active     <= state_nxt != SCR_NORMAL;
            clock_stop_ok <= state_nxt == SCR_CLK_STOP;
        end
    end

    a_stop_needs_sr: assert property (@(posedge clock) disable iff (rst)
        clock_stop_ok |-> sr_active)
        else $error("clock stop outside self-refresh");

    a_stop_needs_bit: assert property (@(posedge clock) disable iff (rst)
        !stop_allow |=> !clock_stop_ok)
        else $error("clock stop without permission");

    a_sr_follow: assert property (@(posedge clock) disable iff (rst)
        sr_req ##1 sr_req |=> sr_active)
        else $error("self-refresh not entered");

endmodule : scr_self_refresh_fsm

// [rtl/scr_top.sv]
// register file, config decode and refresh control of the sdram controller
// assumes a simple single-cycle register master on the same clock
//
// The register offsets and the plain strobed port were left to the implementer.
module scr_top
    import scr_pkg::*;
#(
    parameter logic [31:0] TIM1_RESET = SCR_T1_RESET
) (
    input  wire logic        clock,                 // 25 MHz clock
    input  wire logic        rst,                   // async reset, active high
    input  wire logic [7:0]  addr,                  // register byte address
    input  wire logic [31:0] wdata,                 // write data
    input  wire logic        wr_en,                 // write strobe
    input  wire logic        rd_en,                 // read strobe
    output logic      [31:0] rdata,                 // read data, cycle after strobe
    output logic      [2:0]  cas_latency,           // raw latency code
    output logic      [2:0]  read_latency,          // decoded latency
    output logic      [2:0]  internal_bank_count,   // raw bank code
    output logic      [3:0]  bank_count,            // decoded banks
    output logic      [2:0]  page_size_code,        // raw page code
    output logic      [3:0]  column_bits,           // decoded column bits
    output logic             config_supported,      // all codes valid
    output logic             memory_drive_strength, // 1 weak drive
    output logic      [31:0] timing_reg_one,        // first timing register
    output logic      [31:0] timing_reg_two,        // second timing register
    output logic             init_start,            // start init pulse
    output logic             refresh_request,       // auto-refresh pulse
    output logic             self_refresh_active,   // in self-refresh
    output logic             memory_clock_stop_ok   // clock may stop
);

    logic [31:0] bank_config_reg;
    logic [31:0] refresh_control_reg;
    logic [31:0] bank_nxt;
    logic [15:0] interval_nxt;
    logic [15:0] refresh_count;
    logic        wr_bank;
    logic        wr_refresh;
    logic        wr_tim1;
    logic        wr_tim2;
    logic        drive_bit;

    function automatic logic [2:0] latency_of(input logic [2:0] code);
        latency_of = (code >= 3'h2 && code <= 3'h5) ? code : 3'h0;
    endfunction : latency_of

    function automatic logic [3:0] banks_of(input logic [2:0] code);
        banks_of = (code <= 3'h3) ? 4'h1 << code[1:0] : 4'h0;
    endfunction : banks_of

    function automatic logic [3:0] columns_of(input logic [2:0] code);
        columns_of = (code <= 3'h3) ? 4'h8 + {2'b00, code[1:0]} : 4'h0;
    endfunction : columns_of

    function automatic logic [9:0] init_fields(input logic [31:0] bc);
        init_fields = {bc[SCR_BC_DRIVE], bc[SCR_BC_CL_LSB +: 3],
                       bc[SCR_BC_BANK_LSB +: 3], bc[SCR_BC_PAGE_LSB +: 3]};
    endfunction : init_fields

    assign wr_bank    = wr_en && addr == SCR_OFS_BANK;
    assign wr_refresh = wr_en && addr == SCR_OFS_REFRESH;
    assign wr_tim1    = wr_en && addr == SCR_OFS_TIM1;
    assign wr_tim2    = wr_en && addr == SCR_OFS_TIM2;

    // drive strength moves only when the previous write left boot unlock set
    assign drive_bit = bank_config_reg[SCR_BC_BOOT_UNLOCK] ? wdata[SCR_BC_DRIVE]
                                                           : bank_config_reg[SCR_BC_DRIVE];

    // bit 3 is not stored, so a stray 1 from software cannot stick
    always_comb begin
        bank_nxt = (wdata & SCR_BC_WMASK) | SCR_BC_FIXED;
        bank_nxt[SCR_BC_DRIVE] = drive_bit;
    end

    always_comb begin
        if (wdata[15:0] < SCR_RR_MIN) begin
            interval_nxt = {8'h00, timing_reg_one[SCR_T1_RFC_LSB +: 7], 1'b0};
        end else begin
            interval_nxt = wdata[15:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bank_config_reg <= SCR_BC_RESET;
        end else if (wr_bank) begin
            bank_config_reg <= bank_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refresh_control_reg <= SCR_RC_RESET;
        end else if (wr_refresh) begin
            // bit 23 is kept as written; software is expected to leave it 0
            refresh_control_reg <= {wdata[31:16] & SCR_RC_WMASK[31:16], interval_nxt};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timing_reg_one <= TIM1_RESET;
        end else if (wr_tim1 && bank_config_reg[SCR_BC_TIM_UNLOCK]) begin
            timing_reg_one <= wdata & SCR_T1_WMASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timing_reg_two <= SCR_T2_RESET;
        end else if (wr_tim2 && bank_config_reg[SCR_BC_TIM_UNLOCK]) begin
            timing_reg_two <= wdata & SCR_T2_WMASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_start <= 1'b0;
        end else begin
            init_start <= wr_bank && init_fields(bank_nxt) != init_fields(bank_config_reg);
        end
    end

    // decoded views lag the register by one cycle to stay registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cas_latency           <= SCR_BC_RESET[SCR_BC_CL_LSB +: 3];
            read_latency          <= latency_of(SCR_BC_RESET[SCR_BC_CL_LSB +: 3]);
            internal_bank_count   <= SCR_BC_RESET[SCR_BC_BANK_LSB +: 3];
            bank_count            <= banks_of(SCR_BC_RESET[SCR_BC_BANK_LSB +: 3]);
            page_size_code        <= SCR_BC_RESET[SCR_BC_PAGE_LSB +: 3];
            column_bits           <= columns_of(SCR_BC_RESET[SCR_BC_PAGE_LSB +: 3]);
            memory_drive_strength <= SCR_BC_RESET[SCR_BC_DRIVE];
        end else begin
            cas_latency           <= bank_config_reg[SCR_BC_CL_LSB +: 3];
            read_latency          <= latency_of(bank_config_reg[SCR_BC_CL_LSB +: 3]);
            internal_bank_count   <= bank_config_reg[SCR_BC_BANK_LSB +: 3];
            bank_count            <= banks_of(bank_config_reg[SCR_BC_BANK_LSB +: 3]);
            page_size_code        <= bank_config_reg[SCR_BC_PAGE_LSB +: 3];
            column_bits           <= columns_of(bank_config_reg[SCR_BC_PAGE_LSB +: 3]);
            memory_drive_strength <= bank_config_reg[SCR_BC_DRIVE];
        end
    end

    // reserved codes decode to zero and clear this flag; nothing else reacts
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            config_supported <= 1'b1;
        end else begin
            config_supported <= latency_of(bank_config_reg[SCR_BC_CL_LSB +: 3]) != 3'h0
                && banks_of(bank_config_reg[SCR_BC_BANK_LSB +: 3]) != 4'h0
                && columns_of(bank_config_reg[SCR_BC_PAGE_LSB +: 3]) != 4'h0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                SCR_OFS_STATUS: begin
                    rdata <= {refresh_count, 13'h0, config_supported,
                              memory_clock_stop_ok, self_refresh_active};
                end
                SCR_OFS_BANK:    rdata <= bank_config_reg;
                SCR_OFS_REFRESH: rdata <= refresh_control_reg;
                SCR_OFS_TIM1:    rdata <= timing_reg_one;
                SCR_OFS_TIM2:    rdata <= timing_reg_two;
                default:         rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    scr_self_refresh_fsm u_sr (
        .clock         (clock),
        .rst           (rst),
        .sr_req        (refresh_control_reg[SCR_RC_SELF_REF]),
        .stop_allow    (refresh_control_reg[SCR_RC_CLK_STOP]),
        .sr_active     (self_refresh_active),
        .clock_stop_ok (memory_clock_stop_ok)
    );

    // memory refreshes itself during self-refresh, so auto-refresh pauses;
    // the request bit gates too, so no pulse lands as self-refresh begins
    scr_refresh_timer #(
        .W (16)
    ) u_timer (
        .clock           (clock),
        .rst             (rst),
        .enable          (!self_refresh_active && !refresh_control_reg[SCR_RC_SELF_REF]),
        .restart         (wr_refresh),
        .interval        (refresh_control_reg[15:0]),
        .refresh_request (refresh_request),
        .count           (refresh_count)
    );

    a_tim_locked: assert property (@(posedge clock) disable iff (rst)
        wr_tim1 && !bank_config_reg[SCR_BC_TIM_UNLOCK] |=> $stable(timing_reg_one))
        else $error("locked timing write changed register");

    a_tim_unlocked: assert property (@(posedge clock) disable iff (rst)
        wr_tim1 && bank_config_reg[SCR_BC_TIM_UNLOCK]
        |=> timing_reg_one == ($past(wdata) & SCR_T1_WMASK))
        else $error("unlocked timing write lost");

    a_tim2_locked: assert property (@(posedge clock) disable iff (rst)
        wr_tim2 && !bank_config_reg[SCR_BC_TIM_UNLOCK] |=> $stable(timing_reg_two))
        else $error("locked second timing write changed register");

    a_rr_floor: assert property (@(posedge clock) disable iff (rst)
        wr_refresh && wdata[15:0] < 16'h0100
        |=> refresh_control_reg[15:0] == {8'h00, $past(timing_reg_one[31:25]), 1'b0})
        else $error("small interval not replaced");

    a_rr_direct: assert property (@(posedge clock) disable iff (rst)
        wr_refresh && wdata[15:0] >= 16'h0100
        |=> refresh_control_reg[15:0] == $past(wdata[15:0]))
        else $error("interval not stored");

    a_init_change: assert property (@(posedge clock) disable iff (rst)
        wr_bank && wdata[11:9] != bank_config_reg[11:9] |=> init_start)
        else $error("latency change did not start init");

    a_init_quiet: assert property (@(posedge clock) disable iff (rst)
        !wr_bank |=> !init_start)
        else $error("init started without write");

    a_latency_map: assert property (@(posedge clock) disable iff (rst)
        bank_config_reg[11:9] == 3'h4 ##1 $stable(bank_config_reg[11:9])
        |-> read_latency == 3'h4)
        else $error("latency decode wrong");

    a_bank_map: assert property (@(posedge clock) disable iff (rst)
        bank_config_reg[6:4] == 3'h3 ##1 $stable(bank_config_reg[6:4])
        |-> bank_count == 4'h8)
        else $error("bank decode wrong");

    a_page_map: assert property (@(posedge clock) disable iff (rst)
        bank_config_reg[2:0] == 3'h2 ##1 $stable(bank_config_reg[2:0])
        |-> column_bits == 4'ha)
        else $error("column decode wrong");

    a_stop_only_sr: assert property (@(posedge clock) disable iff (rst)
        !refresh_control_reg[31] ##1 !refresh_control_reg[31] |-> !memory_clock_stop_ok)
        else $error("clock stop in normal operation");

    a_reads_zero: assert property (@(posedge clock) disable iff (rst)
        !rd_en |=> rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

endmodule : scr_top

// [testbench/scr_sdram_model.sv]
// far-side memory model: takes refresh commands and watches the clock-stop permission
// assumes it sees the controller outputs on the controller clock
module scr_sdram_model (
    input  wire logic clock,                // system clock
    input  wire logic rst,                  // async reset, active high
    input  wire logic refresh_request,      // auto-refresh command
    input  wire logic self_refresh_active,  // memory held in self-refresh
    input  wire logic memory_clock_stop_ok, // memory clock may stop
    output int        refreshes,            // refresh commands taken
    output int        faults                // illegal events seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // a real part loses data if refreshed inside self-refresh or clock-stopped outside it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            refreshes <= 0;
            faults <= 0;
        end else begin
            if (refresh_request) begin
                refreshes <= refreshes + 1;
            end
            if ((refresh_request && self_refresh_active) ||
                (memory_clock_stop_ok && !self_refresh_active)) begin
                faults <= faults + 1;
            end
        end
    end
endmodule : scr_sdram_model

// [testbench/scr_top_tb_top.sv]
// self-checking bench for the configuration and refresh block, register model in the bench
// assumes the register port contract of the block and a 25 MHz clock
module scr_top_tb_top;
    import scr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, rst, wr_en, rd_en, init_start, refresh_request;
    logic [7:0]  addr, seed;
    logic [31:0] wdata, rdata, timing_reg_one, timing_reg_two, d;
    logic [31:0] exp_bc, exp_rc, exp_t1, exp_t2;
    logic [2:0]  cas_latency, read_latency, internal_bank_count, page_size_code;
    logic [3:0]  bank_count, column_bits;
    logic        config_supported, memory_drive_strength;
    logic        self_refresh_active, memory_clock_stop_ok;
    int          mismatches, checked, inits, pulses, gap, last, cyc, refreshes, faults, n;

    scr_top i_scr_top (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .cas_latency(cas_latency), .read_latency(read_latency),
        .internal_bank_count(internal_bank_count), .bank_count(bank_count),
        .page_size_code(page_size_code), .column_bits(column_bits),
        .config_supported(config_supported), .memory_drive_strength(memory_drive_strength),
        .timing_reg_one(timing_reg_one), .timing_reg_two(timing_reg_two),
        .init_start(init_start), .refresh_request(refresh_request),
        .self_refresh_active(self_refresh_active), .memory_clock_stop_ok(memory_clock_stop_ok));

    scr_sdram_model i_scr_sdram_model (.clock(clock), .rst(rst),
        .refresh_request(refresh_request), .self_refresh_active(self_refresh_active),
        .memory_clock_stop_ok(memory_clock_stop_ok), .refreshes(refreshes), .faults(faults));

    initial clock = 1'b0;
    always #20 clock = ~clock;

    // pulse counters instead of exact-cycle probes, so latency choices do not matter
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (init_start === 1'b1) inits <= inits + 1;
        if (refresh_request === 1'b1) begin
            gap <= cyc - last;
            last <= cyc;
            pulses <= pulses + 1;
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic wait_n(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : wait_n

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] old;
        int          n0;
        old = exp_bc;
        n0 = inits;
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        case (a)
            SCR_OFS_BANK: exp_bc = (v & SCR_BC_WMASK) | SCR_BC_FIXED |
                                   {13'h0, old[23] ? v[18] : old[18], 18'h0};
            SCR_OFS_REFRESH: begin
                exp_rc = v & SCR_RC_WMASK;
                if (v[15:0] < SCR_RR_MIN) exp_rc[15:0] = {8'h0, exp_t1[31:25], 1'b0};
            end
            SCR_OFS_TIM1: if (exp_bc[15]) exp_t1 = v & SCR_T1_WMASK;
            SCR_OFS_TIM2: if (exp_bc[15]) exp_t2 = v & SCR_T2_WMASK;
            default: ;
        endcase
        if (a == SCR_OFS_BANK) begin
            wait_n(3);
            cmp_val(inits - n0, ((old ^ exp_bc) & 32'h00040e77) != 0);
        end
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
        cmp_val(d, e);
    endtask : chk

    task automatic chk_regs;
        chk(SCR_OFS_BANK, exp_bc);
        chk(SCR_OFS_REFRESH, exp_rc);
        chk(SCR_OFS_TIM1, exp_t1);
        chk(SCR_OFS_TIM2, exp_t2);
        cmp_val(timing_reg_one, exp_t1);
        cmp_val(timing_reg_two, exp_t2);
    endtask : chk_regs

    task automatic chk_dec;
        logic [2:0] c, b, p;
        c = exp_bc[11:9];
        b = exp_bc[6:4];
        p = exp_bc[2:0];
        cmp_val({read_latency, cas_latency}, {(c >= 2 && c <= 5) ? c : 3'h0, c});
        cmp_val({bank_count, internal_bank_count}, {b < 4 ? 4'h1 << b : 4'h0, b});
        cmp_val({column_bits, page_size_code}, {p < 4 ? 4'h8 + {1'b0, p} : 4'h0, p});
        cmp_val(config_supported, (c >= 2 && c <= 5) && b < 4 && p < 4);
        cmp_val(memory_drive_strength, exp_bc[18]);
    endtask : chk_dec

    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        seed = 8'h23;
        exp_bc = SCR_BC_RESET;
        exp_rc = SCR_RC_RESET;
        exp_t1 = SCR_T1_RESET;
        exp_t2 = SCR_T2_RESET;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        chk_regs();
        chk_dec();
        chk(8'h04, 32'h0);
        wr(8'h04, 32'hffffffff);
        wr(SCR_OFS_TIM1, 32'hffffffff);
        wr(SCR_OFS_TIM2, 32'hffffffff);
        chk_regs();
        // every cas code once, bank and page codes random; bit 3 always 0
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(SCR_OFS_BANK, SCR_BC_FIXED | 32'h8000 | {20'h0, 3'(i), 9'h0} |
               {25'h0, seed[2:0], 4'h0} | {29'h0, seed[5:3]});
            chk_dec();
        end
        wr(SCR_OFS_BANK, exp_bc | 32'h00040000);
        wr(SCR_OFS_BANK, exp_bc | 32'h00800000);
        wr(SCR_OFS_BANK, exp_bc & ~32'h00840000);
        chk_dec();
        seed = lfsr(seed);
        wr(SCR_OFS_TIM1, {seed[6:0], 25'h155aaa5});
        wr(SCR_OFS_TIM2, 32'hffffffff);
        wr(SCR_OFS_REFRESH, {24'h0, seed});
        chk_regs();
        wr(SCR_OFS_REFRESH, {16'h0, 8'h01, seed});
        n = pulses;
        for (int k = 0; k < 1500 && pulses < n + 3; k++) @(posedge clock);
        cmp_val(gap, {16'h0, 8'h01, seed});
        // stop permission without self-refresh must not stop the clock
        wr(SCR_OFS_REFRESH, 32'h40000100);
        wait_n(4);
        cmp_val({self_refresh_active, memory_clock_stop_ok}, 2'b00);
        wr(SCR_OFS_REFRESH, 32'h80000100);
        wait_n(3);
        n = pulses;
        cmp_val({self_refresh_active, memory_clock_stop_ok}, 2'b10);
        wait_n(300);
        cmp_val(pulses - n, 0);
        wr(SCR_OFS_REFRESH, 32'hc0000100);
        wait_n(3);
        // counter held at 0 in self-refresh; supported bit from the bank codes
        chk(SCR_OFS_STATUS, {29'h0, exp_bc[11:9] >= 2 && exp_bc[11:9] <= 5 &&
            exp_bc[6:4] < 4 && exp_bc[2:0] < 4, 2'b11});
        cmp_val({d[1:0], self_refresh_active, memory_clock_stop_ok}, 4'hf);
        wr(SCR_OFS_REFRESH, 32'h00000100);
        wait_n(3);
        cmp_val({self_refresh_active, memory_clock_stop_ok}, 2'b00);
        wait_n(600);
        cmp_val(refreshes > 0 && faults == 0, 1'b1);
        final_report();
    end
endmodule : scr_top_tb_top
